// ==== logic/pcsb_core.sv ====
// Purpose: Program counter, return stack and banked data addressing.
// Assumes: Core decode signals share aclk; ROM and SPECIAL_FUNCTION_REGISTER arrays sit outside.
// Notes:   Data accesses are pipelined, one may start every cycle.
// Functional notes
// - Program counter is eleven bits wide
// - Reset loads program counter with zero
// - Software interrupt branches to address one
// - Hardware interrupts share vector eight
// - Short jump/call stay in 256 page
// - Call or interrupt pushes next address
// - Three returns pop top into counter
// - Return stack holds eight entries
// - 0x00E-0x00F preset code until released
// - Status bits 7:6 pick one of four banks
// - Indirect register access goes to pointer
// - Indirect uses bank bits and pointer low seven
// - Direct uses bank bits and opcode low seven
// - Ordinary instructions reach general special registers
// - Special registers at 0x0-0x1F of bank 0
// - General RAM is 128 bytes of SRAM
// - Special range in banks 1-3 maps to 0
// - RAM physical in bank 0 and bank 1 low
// - Port page ignores bank bits
// - Peripheral page ignores bank bits
//
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`default_nettype none
module pcsb_core #(
  parameter int STACK_DEPTH = pcsb_pkg::STACK_DEPTH,
  parameter int RAM_WORDS = pcsb_pkg::RAM_WORDS
) (
  input wire logic aclk,
  input wire logic aresetn,
  // Program-flow operation from the core
  input wire logic instr_valid,
  input wire pcsb_pkg::pcsb_instr_t instr_kind,
  input wire logic [10:0] instr_target,
  output logic [10:0] program_counter,
  output logic fetch_preset_sel,
  // Data access from the core
  input wire pcsb_pkg::pcsb_dreq_t data_req,
  output logic data_rvalid,
  output logic [7:0] data_rdata,
  output logic [8:0] full_data_addr,
  // General-page special registers outside
  output logic sfr_rd,
  output logic sfr_wr,
  output logic [4:0] sfr_addr,
  output logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  // Port and peripheral pages outside
  output logic page_rd,
  output logic page_wr,
  output logic page_is_periph,
  output logic [4:0] page_addr,
  output logic [7:0] page_wdata,
  input wire logic [7:0] page_rdata,
  // AXI4-Lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [10:0] program_counter_q;
  logic [10:0] pc_next_word;
  logic [10:0] ret_top;
  logic [3:0] stack_count;
  logic do_push;
  logic do_pop;
  // Software may release the preset code words
  logic release_q;
  // Bank select and file pointer live here
  logic [1:0] bank_select_bits_q;
  logic [7:0] file_pointer_register_q;
  // Decode of the current data request
  logic [6:0] eff_loc;
  pcsb_pkg::pcsb_dst_t dst_d;
  logic [6:0] ram_addr_d;
  // Stage one of the data pipeline
  pcsb_pkg::pcsb_dst_t dst_q;
  logic write_q;
  logic valid_q;
  logic [6:0] ram_addr_q;
  // Stage two: result source and captured bytes
  pcsb_pkg::pcsb_dst_t src_q;
  logic [7:0] ext_q;
  logic [7:0] ram_rdata_q;
  logic ram_en;
  // Bus write holding
  logic aw_hold_q;
  logic w_hold_q;
  logic [3:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // Map a banked general location onto the physical byte array
  function automatic logic [6:0] map_ram(input logic [1:0] bank,
                                         input logic [6:0] loc);
    // Banks 1 and 3 low half share bank 1 bytes; all else is bank 0
    map_ram = (!loc[6] && bank[0]) ?
      pcsb_pkg::RAM_BANK1_BASE + {2'h0, loc[4:0]} :
      loc - pcsb_pkg::LOC_GP_BASE;
  endfunction

  assign program_counter = program_counter_q;
  assign pc_next_word = program_counter_q + 11'h001;

  // Calls and accepted interrupts save the next word
  assign do_push = instr_valid &&
    (instr_kind == pcsb_pkg::INS_SHORT_CALL ||
     instr_kind == pcsb_pkg::INS_LONG_CALL ||
     instr_kind == pcsb_pkg::INS_SW_INT ||
     instr_kind == pcsb_pkg::INS_HW_INT);
  // All three returns restore from the stack
  assign do_pop = instr_valid &&
    (instr_kind == pcsb_pkg::INS_RET_PLAIN ||
     instr_kind == pcsb_pkg::INS_RET_LIT ||
     instr_kind == pcsb_pkg::INS_RET_INT);

  pcsb_ret_stack #(
    .DEPTH(STACK_DEPTH),
    .WIDTH(pcsb_pkg::PC_W),
    .CNT_W(pcsb_pkg::STACK_CNT_W)
  ) u_stack (
    .aclk(aclk),
    .aresetn(aresetn),
    .push(do_push),
    .pop(do_pop),
    .push_data(pc_next_word),
    .top_data(ret_top),
    .count(stack_count)
  );

  // Program counter sequencing
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      program_counter_q <= pcsb_pkg::VEC_RESET;
    end
    else if (instr_valid)
    begin
      case (instr_kind)
        // short reach keeps the current 256-word page
        pcsb_pkg::INS_SHORT_JUMP, pcsb_pkg::INS_SHORT_CALL:
          program_counter_q <= {program_counter_q[10:8],
                                instr_target[7:0]};
        // long reach covers all program space
        pcsb_pkg::INS_LONG_JUMP, pcsb_pkg::INS_LONG_CALL:
          program_counter_q <= instr_target;
        pcsb_pkg::INS_RET_PLAIN, pcsb_pkg::INS_RET_LIT,
        pcsb_pkg::INS_RET_INT:
          program_counter_q <= ret_top;
        pcsb_pkg::INS_SW_INT:
          program_counter_q <= pcsb_pkg::VEC_SW_INT;
        pcsb_pkg::INS_HW_INT:
          program_counter_q <= pcsb_pkg::VEC_HW_INT;
        default:
          program_counter_q <= pc_next_word;
      endcase
    end
  end

  // preset words shadow the fetch until software releases them
  assign fetch_preset_sel = !release_q &&
    (program_counter_q == pcsb_pkg::PRESET_LO ||
     program_counter_q == pcsb_pkg::PRESET_HI);

  // indirect register is replaced by the pointer location
  // direct access uses the opcode location
  assign eff_loc = (data_req.loc == pcsb_pkg::LOC_INDIRECT) ?
    file_pointer_register_q[6:0] : data_req.loc;

  // Data access decode
  always_comb
  begin
    dst_d = pcsb_pkg::DST_NONE;
    ram_addr_d = map_ram(bank_select_bits_q, eff_loc);
    if (!data_req.valid)
    begin
      dst_d = pcsb_pkg::DST_NONE;
    end
    // dedicated pages never look at bank bits
    else if (data_req.page != pcsb_pkg::PAGE_R)
    begin
      dst_d = pcsb_pkg::DST_PAGE;
    end
    // Pointer aimed at the indirect register reads zero, drops writes
    else if (eff_loc == pcsb_pkg::LOC_INDIRECT)
    begin
      dst_d = pcsb_pkg::DST_NONE;
    end
    else if (eff_loc == pcsb_pkg::LOC_FILE_PTR)
    begin
      dst_d = pcsb_pkg::DST_FILE_PTR;
    end
    else if (eff_loc == pcsb_pkg::LOC_STATUS)
    begin
      dst_d = pcsb_pkg::DST_STATUS;
    end
    // low range is bank 0 registers in every bank
    else if (eff_loc < pcsb_pkg::LOC_GP_BASE)
    begin
      dst_d = pcsb_pkg::DST_SFR;
    end
    else
    begin
      dst_d = pcsb_pkg::DST_RAM;
    end
  end

  // Pointer and bank bits update at acceptance so the next
  // back-to-back request already sees the new value
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      file_pointer_register_q <= pcsb_pkg::FILE_PTR_RST;
      bank_select_bits_q <= pcsb_pkg::BANK_RST;
    end
    else if (data_req.write)
    begin
      if (dst_d == pcsb_pkg::DST_FILE_PTR)
      begin
        file_pointer_register_q <= data_req.wdata;
      end
      // status bits 7:6 are the bank select
      if (dst_d == pcsb_pkg::DST_STATUS)
      begin
        bank_select_bits_q <= data_req.wdata[pcsb_pkg::STATUS_BANK_LSB +: 2];
      end
    end
  end

  // Stage one: registered strobes toward the outside arrays
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dst_q <= pcsb_pkg::DST_NONE;
      write_q <= 1'b0;
      valid_q <= 1'b0;
      sfr_rd <= 1'b0;
      sfr_wr <= 1'b0;
      page_rd <= 1'b0;
      page_wr <= 1'b0;
      page_is_periph <= 1'b0;
      full_data_addr <= '0;
    end
    else
    begin
      dst_q <= dst_d;
      write_q <= data_req.write;
      valid_q <= data_req.valid;
      ram_addr_q <= ram_addr_d;
      // Status goes out too; only its bank bits are kept here
      sfr_rd <= !data_req.write && (dst_d == pcsb_pkg::DST_SFR ||
                                    dst_d == pcsb_pkg::DST_STATUS);
      sfr_wr <= data_req.write && (dst_d == pcsb_pkg::DST_SFR ||
                                   dst_d == pcsb_pkg::DST_STATUS);
      sfr_addr <= eff_loc[4:0];
      sfr_wdata <= data_req.wdata;
      page_rd <= !data_req.write && dst_d == pcsb_pkg::DST_PAGE;
      page_wr <= data_req.write && dst_d == pcsb_pkg::DST_PAGE;
      page_is_periph <= data_req.page == pcsb_pkg::PAGE_PERIPH;
      page_addr <= data_req.loc[4:0];
      page_wdata <= data_req.wdata;
      // bank bits sit above the seven-bit location
      full_data_addr <= {bank_select_bits_q, eff_loc};
    end
  end

  assign ram_en = dst_q == pcsb_pkg::DST_RAM;

  pcsb_gp_ram #(
    .WORDS(RAM_WORDS),
    .AW(pcsb_pkg::RAM_AW),
    .DW(pcsb_pkg::DATA_W)
  ) u_ram (
    .aclk(aclk),
    .en(ram_en),
    .we(write_q),
    .addr(ram_addr_q),
    .wdata(sfr_wdata),
    .rdata_q(ram_rdata_q)
  );

  // Stage two: capture outside read data, flag the answer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      src_q <= pcsb_pkg::DST_NONE;
      ext_q <= '0;
      data_rvalid <= 1'b0;
    end
    else
    begin
      src_q <= dst_q;
      data_rvalid <= valid_q && !write_q;
      case (dst_q)
        pcsb_pkg::DST_PAGE: ext_q <= page_rdata;
        pcsb_pkg::DST_SFR: ext_q <= sfr_rdata;
        // Outside status with the bank bits put in
        pcsb_pkg::DST_STATUS:
          ext_q <= {bank_select_bits_q, sfr_rdata[5:0]};
        pcsb_pkg::DST_FILE_PTR: ext_q <= file_pointer_register_q;
        default: ext_q <= '0;
      endcase
    end
  end

  // Both sources are flops; the mux only picks one
  assign data_rdata = (src_q == pcsb_pkg::DST_RAM) ? ram_rdata_q : ext_q;

  // Bus write address and data are taken independently
  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready = !w_hold_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // Write channel collect, perform, respond
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= pcsb_pkg::RESP_OKAY;
      release_q <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (aw_hold_q && w_hold_q && !bvalid_q)
      begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= pcsb_pkg::RESP_OKAY;
        // Every offset decodes; status words drop writes quietly
        if ({awaddr_q[3:2], 2'h0} == pcsb_pkg::REG_CTRL && wstrb_q[0])
        begin
          release_q <= wdata_q[pcsb_pkg::CTRL_RELEASE_BIT];
        end
      end
      else if (bvalid_q && s_axi_bready)
      begin
        bvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // Read channel: answer one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= pcsb_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_q <= 1'b1;
      rresp_q <= pcsb_pkg::RESP_OKAY;
      case ({s_axi_araddr[3:2], 2'h0})
        pcsb_pkg::REG_CTRL:
          rdata_q <= {31'h0, release_q};
        pcsb_pkg::REG_PC_STAT:
          rdata_q <= {21'h0, program_counter_q};
        pcsb_pkg::REG_STACK_STAT:
          rdata_q <= {28'h0, stack_count};
        pcsb_pkg::REG_ADDR_STAT:
          rdata_q <= {22'h0, bank_select_bits_q, file_pointer_register_q};
        default:
        begin
          rdata_q <= '0;
          rresp_q <= pcsb_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_q && s_axi_rready)
    begin
      rvalid_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== logic/pcsb_pkg.sv ====
// Purpose: Shared constants and types of the program-flow block.
// Assumes: One system clock, synchronous active-low reset.
// Notes:   Every offset, vector and width used by more than one file.
`default_nettype none
package pcsb_pkg;
  // Program side widths and vectors
  localparam int PC_W = 11;
  localparam int PROG_WORDS = 1280;
  localparam logic [10:0] VEC_RESET = 11'h000;
  localparam logic [10:0] VEC_SW_INT = 11'h001;
  localparam logic [10:0] VEC_HW_INT = 11'h008;
  localparam logic [10:0] PRESET_LO = 11'h00e;
  localparam logic [10:0] PRESET_HI = 11'h00f;
  localparam logic [10:0] RSVD_LO = 11'h4fe;
  localparam logic [10:0] RSVD_HI = 11'h4ff;
  localparam int SHORT_W = 8;
  localparam int STACK_DEPTH = 8;
  localparam int STACK_CNT_W = 4;

  // Data side widths and map
  localparam int LOC_W = 7;
  localparam int BANK_W = 2;
  localparam int DATA_W = 8;
  localparam int SFR_AW = 5;
  localparam int RAM_WORDS = 128;
  localparam int RAM_AW = 7;
  localparam logic [6:0] LOC_INDIRECT = 7'h00;
  localparam logic [6:0] LOC_STATUS = 7'h03;
  localparam logic [6:0] LOC_FILE_PTR = 7'h04;
  localparam logic [6:0] LOC_GP_BASE = 7'h20;
  localparam logic [6:0] RAM_BANK1_BASE = 7'h60;
  localparam int STATUS_BANK_LSB = 6;
  localparam logic [7:0] FILE_PTR_RST = 8'h00;
  localparam logic [1:0] BANK_RST = 2'h0;

  // Register bus map
  localparam int AXI_AW = 4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_PC_STAT = 4'h4;
  localparam logic [3:0] REG_STACK_STAT = 4'h8;
  localparam logic [3:0] REG_ADDR_STAT = 4'hc;
  localparam int CTRL_RELEASE_BIT = 0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Program-flow operation reported by the core
  typedef enum logic [3:0] {
    INS_STEP = 4'h0,
    INS_SHORT_JUMP = 4'h1,
    INS_SHORT_CALL = 4'h2,
    INS_LONG_JUMP = 4'h3,
    INS_LONG_CALL = 4'h4,
    INS_RET_PLAIN = 4'h5,
    INS_RET_LIT = 4'h6,
    INS_RET_INT = 4'h7,
    INS_SW_INT = 4'h8,
    INS_HW_INT = 4'h9
  } pcsb_instr_t;

  // Data page selected by the instruction class
  typedef enum logic [1:0] {
    PAGE_R = 2'h0,
    PAGE_PORT = 2'h1,
    PAGE_PERIPH = 2'h2
  } pcsb_page_t;

  // Where a decoded data access lands
  typedef enum logic [2:0] {
    DST_NONE = 3'h0,
    DST_RAM = 3'h1,
    DST_SFR = 3'h2,
    DST_PAGE = 3'h3,
    DST_FILE_PTR = 3'h4,
    DST_STATUS = 3'h5
  } pcsb_dst_t;

  // One data access request from the core
  typedef struct packed {
    logic valid;
    logic write;
    pcsb_page_t page;
    logic [6:0] loc;
    logic [7:0] wdata;
  } pcsb_dreq_t;
endpackage
`default_nettype wire

// ==== logic/pcsb_ret_stack.sv ====
// Purpose: Return-address stack kept in flip-flops.
// Assumes: Push and pop never come in the same cycle.
// Notes:   Circular; a push on a full stack drops the oldest entry.
`default_nettype none
module pcsb_ret_stack #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 11,
  parameter int CNT_W = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic push,
  input wire logic pop,
  input wire logic [WIDTH-1:0] push_data,
  output logic [WIDTH-1:0] top_data,
  output logic [CNT_W-1:0] count
);
  localparam int PW = $clog2(DEPTH);
  // Entry storage
  logic [WIDTH-1:0] mem_q [DEPTH];
  // Index of the next free slot
  logic [PW-1:0] wp_q;
  logic [CNT_W-1:0] cnt_q;

  // Top sits below the write pointer; empty shows a stale slot
  assign top_data = mem_q[wp_q - PW'(1)];
  assign count = cnt_q;

  // Entry write
  always_ff @(posedge aclk)
  begin
    if (push)
    begin
      mem_q[wp_q] <= push_data;
    end
  end

  // Pointer and fill level
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wp_q <= '0;
      cnt_q <= '0;
    end
    else if (push)
    begin
      wp_q <= wp_q + PW'(1);
      if (cnt_q != CNT_W'(DEPTH))
      begin
        cnt_q <= cnt_q + CNT_W'(1);
      end
    end
    else if (pop)
    begin
      wp_q <= wp_q - PW'(1);
      // Underflow is silent and keeps the level at zero
      if (cnt_q != '0)
      begin
        cnt_q <= cnt_q - CNT_W'(1);
      end
    end
  end
endmodule
`default_nettype wire

// ==== logic/pcsb_gp_ram.sv ====
// Purpose: General-purpose data SRAM, single port.
// Assumes: Read data is wanted one cycle after the access.
// Notes:   Read data leaves from a register; contents are not reset.
`default_nettype none
module pcsb_gp_ram #(
  parameter int WORDS = 128,
  parameter int AW = 7,
  parameter int DW = 8
) (
  input wire logic aclk,
  input wire logic en,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata_q
);
  // Byte array
  logic [DW-1:0] mem_q [WORDS];

  // Access port; a write also returns the new byte
  always_ff @(posedge aclk)
  begin
    if (en)
    begin
      if (we)
      begin
        mem_q[addr] <= wdata;
        rdata_q <= wdata;
      end
      else
      begin
        rdata_q <= mem_q[addr];
      end
    end
  end
endmodule
`default_nettype wire

// ==== verif/pcsb_core_sva.sv ====
// Purpose: Port-level checks on the program-flow and data-address block.
// Assumes: One clock domain, synchronous active-low reset.
// Notes:   Bound from the bench top; sees top-level ports only.
`default_nettype none
module pcsb_core_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic instr_valid,
  input wire pcsb_pkg::pcsb_instr_t instr_kind,
  input wire logic [10:0] instr_target,
  input wire logic [10:0] program_counter,
  input wire pcsb_pkg::pcsb_dreq_t data_req,
  input wire logic data_rvalid,
  input wire logic [8:0] full_data_addr,
  input wire logic sfr_rd,
  input wire logic [4:0] sfr_addr,
  input wire logic page_rd,
  input wire logic page_wr,
  input wire logic page_is_periph,
  input wire logic [4:0] page_addr
);
  // Single domain, so clock and disable are shared
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_pc_reset: assert property (
    $rose(aresetn) |-> program_counter == pcsb_pkg::VEC_RESET)
    else $error("pc not at reset vector");
  a_sw_vector: assert property (
    instr_valid && instr_kind == pcsb_pkg::INS_SW_INT
    |=> program_counter == pcsb_pkg::VEC_SW_INT)
    else $error("software vector missed");
  a_hw_vector: assert property (
    instr_valid && instr_kind == pcsb_pkg::INS_HW_INT
    |=> program_counter == pcsb_pkg::VEC_HW_INT)
    else $error("hardware vector missed");
  a_long_reach: assert property (
    instr_valid && instr_kind inside {pcsb_pkg::INS_LONG_JUMP,
    pcsb_pkg::INS_LONG_CALL} |=> program_counter == $past(instr_target))
    else $error("long target missed");
  a_short_reach: assert property (
    instr_valid && instr_kind inside {pcsb_pkg::INS_SHORT_JUMP,
    pcsb_pkg::INS_SHORT_CALL}
    |=> program_counter == {$past(program_counter[10:8]),
    $past(instr_target[7:0])})
    else $error("short target left its page");
  a_step_next: assert property (
    instr_valid && instr_kind == pcsb_pkg::INS_STEP
    |=> program_counter == 11'($past(program_counter) + 11'h001))
    else $error("step did not advance by one");
  a_call_return: assert property (
    instr_valid && instr_kind == pcsb_pkg::INS_LONG_CALL ##1
    instr_valid && instr_kind == pcsb_pkg::INS_RET_PLAIN
    |=> program_counter == 11'($past(program_counter, 2) + 11'h001))
    else $error("return did not resume after call");
  a_sfr_route: assert property (
    data_req.valid && !data_req.write && data_req.page == pcsb_pkg::PAGE_R
    && data_req.loc inside {[7'h01:7'h03], [7'h05:7'h1f]}
    |=> sfr_rd && sfr_addr == $past(data_req.loc[4:0]))
    else $error("special register read not routed");
  a_page_route: assert property (
    data_req.valid && data_req.page != pcsb_pkg::PAGE_R
    |=> (page_rd || page_wr) && page_addr == $past(data_req.loc[4:0]) &&
    page_is_periph == ($past(data_req.page) == pcsb_pkg::PAGE_PERIPH))
    else $error("page access not routed");
  a_read_answer: assert property (
    data_req.valid && !data_req.write |-> ##2 data_rvalid)
    else $error("read answer late or missing");
  a_addr_join: assert property (
    data_req.valid && data_req.page == pcsb_pkg::PAGE_R &&
    data_req.loc >= 7'h20 |=> full_data_addr[6:0] == $past(data_req.loc))
    else $error("direct location not joined");
endmodule
`default_nettype wire

// ==== verif/pcsb_far_model.sv ====
// Purpose: Special register and page arrays beside the block.
// Assumes: Read data wanted in the cycle the read strobe is high.
// Notes:   Idle read lines show the inverse of their last value.
`default_nettype none
module pcsb_far_model (
  input wire logic aclk,
  input wire logic sfr_rd,
  input wire logic sfr_wr,
  input wire logic [4:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic page_rd,
  input wire logic page_wr,
  input wire logic page_is_periph,
  input wire logic [4:0] page_addr,
  input wire logic [7:0] page_wdata,
  output logic [7:0] page_rdata
);
  logic [7:0] sfr_m [32]; // General page, bank 0 only
  logic [7:0] pg_m [64]; // Port page low, peripheral page high
  logic [7:0] last_s_q;
  logic [7:0] last_p_q;
  always_ff @(posedge aclk)
  begin
    if (sfr_wr)
      sfr_m[sfr_addr] <= sfr_wdata;
    if (page_wr)
      pg_m[{page_is_periph, page_addr}] <= page_wdata;
    last_s_q <= sfr_rdata;
    last_p_q <= page_rdata;
  end
  // no bank in page index; stale value never held
  always_comb
  begin
    sfr_rdata = sfr_rd ? sfr_m[sfr_addr] : ~last_s_q;
    page_rdata = page_rd ? pg_m[{page_is_periph, page_addr}] : ~last_p_q;
  end
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
// Purpose: Self-checking bench for the program-flow and data block.
// Assumes: 50 ns clock; reads answered through a queue of notes.
// Notes:   Register bus driven as a simple one-at-a-time master.
`default_nettype none
`define CHK(nm, a, e) begin n_compared++; if ((a) !== (e)) begin \
  miscompares++; $display("[FAIL] %s exp %h got %h", nm, e, a); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, instr_valid, fetch_preset_sel, data_rvalid;
  pcsb_pkg::pcsb_instr_t instr_kind;
  logic [10:0] instr_target, program_counter;
  pcsb_pkg::pcsb_dreq_t data_req;
  logic [7:0] data_rdata, sfr_wdata, sfr_rdata, page_wdata, page_rdata;
  logic [8:0] full_data_addr;
  logic sfr_rd, sfr_wr, page_rd, page_wr, page_is_periph;
  logic [4:0] sfr_addr, page_addr;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, r;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [7:0] v0, v1, v2, e;
  logic [7:0] expq[$]; // Expected read bytes, oldest first
  logic [31:0] seed = 32'd24;
  int miscompares = 0;
  int n_compared = 0;
  localparam pcsb_pkg::pcsb_page_t PG_R = pcsb_pkg::PAGE_R;
  pcsb_core u_dut (.*);
  pcsb_far_model u_far (.*);
  // Free-running system clock
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // Fixed-seed xorshift for data bytes
  function logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic finish_test();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One program-flow op; valid is high for exactly one edge
  task automatic op(input pcsb_pkg::pcsb_instr_t k, input logic [10:0] t);
    instr_kind <= k;
    instr_target <= t;
    instr_valid <= 1'b1;
    @(posedge aclk);
    instr_valid <= 1'b0;
    #1;
  endtask
  task automatic ck(input logic [10:0] x);
    `CHK("pc", program_counter, x)
  endtask
  // One data access; a read leaves its expected byte in the queue
  task automatic dx(input logic w, input pcsb_pkg::pcsb_page_t p,
                    input logic [6:0] l, input logic [7:0] d);
    if (!w)
      expq.push_back(d);
    data_req <= '{1'b1, w, p, l, w ? d : xs()};
    @(posedge aclk);
    data_req <= '0;
    #1;
  endtask
  // Register bus cycle; each valid drops at its own handshake edge
  task automatic axi(input bit w, input logic [3:0] a,
                     input logic [31:0] d);
    bit pend;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
    {s_axi_arvalid, s_axi_rready} <= {2{!w}};
    pend = 1'b1;
    while (pend)
    begin
      @(posedge aclk);
      pend = (s_axi_awvalid && !s_axi_awready) ||
        (s_axi_wvalid && !s_axi_wready) || (s_axi_arvalid && !s_axi_arready);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    do
      @(posedge aclk);
    while (!(w ? s_axi_bvalid : s_axi_rvalid));
    r = s_axi_rdata;
    rs = w ? s_axi_bresp : s_axi_rresp;
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
  endtask
  // Read answers matched against the oldest note
  always @(posedge aclk)
  begin
    if (data_rvalid === 1'b1)
    begin
      e = expq.size() > 0 ? expq.pop_front() : ~data_rdata;
      `CHK("rdata", data_rdata, e)
    end
  end
  // Hang guard, well past the test length
  initial
  begin
    repeat (3000) @(posedge aclk);
    miscompares++;
    finish_test();
  end
  initial
  begin
    {aresetn, instr_valid, instr_target, data_req} = '0;
    instr_kind = pcsb_pkg::INS_STEP;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {s_axi_bready, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    ck(pcsb_pkg::VEC_RESET);
    // no target here lands in the reserved words
    op(pcsb_pkg::INS_LONG_JUMP, pcsb_pkg::PRESET_LO);
    `CHK("preset", fetch_preset_sel, 1'b1)
    op(pcsb_pkg::INS_LONG_CALL, 11'h123);
    op(pcsb_pkg::INS_RET_PLAIN, 11'h000);
    ck(11'h00f);
    op(pcsb_pkg::INS_LONG_JUMP, 11'h345);
    op(pcsb_pkg::INS_SHORT_CALL, 11'h7ab);
    ck(11'h3ab);
    op(pcsb_pkg::INS_RET_LIT, 11'h000);
    op(pcsb_pkg::INS_SW_INT, 11'h000);
    ck(pcsb_pkg::VEC_SW_INT);
    op(pcsb_pkg::INS_RET_INT, 11'h000);
    ck(11'h347);
    op(pcsb_pkg::INS_HW_INT, 11'h000);
    ck(pcsb_pkg::VEC_HW_INT);
    op(pcsb_pkg::INS_LONG_JUMP, 11'h7ff);
    op(pcsb_pkg::INS_STEP, 11'h000);
    ck(11'h000);
    for (int i = 0; i < 9; i++)
      op(pcsb_pkg::INS_LONG_CALL, 11'(11'h100 + i * 16));
    axi(1'b0, pcsb_pkg::REG_STACK_STAT, 32'h0);
    `CHK("depth", r[3:0], 4'h8)
    for (int j = 7; j >= 0; j--)
    begin
      op(pcsb_pkg::pcsb_instr_t'(5 + j % 3), 11'h000);
      ck(11'(11'h101 + j * 16));
    end
    {v0, v1, v2} = {xs(), xs(), xs()};
    dx(1'b1, PG_R, 7'h25, v0);
    dx(1'b1, PG_R, pcsb_pkg::LOC_STATUS, 8'h40);
    dx(1'b1, PG_R, 7'h25, v1);
    dx(1'b1, PG_R, pcsb_pkg::LOC_STATUS, 8'hc0);
    dx(1'b0, PG_R, 7'h25, v1);
    dx(1'b1, PG_R, pcsb_pkg::LOC_STATUS, 8'h80);
    dx(1'b0, PG_R, 7'h25, v0);
    dx(1'b1, PG_R, pcsb_pkg::LOC_FILE_PTR, 8'ha5);
    dx(1'b0, PG_R, pcsb_pkg::LOC_INDIRECT, v0);
    dx(1'b1, PG_R, 7'h10, v2);
    dx(1'b0, PG_R, 7'h10, v2);
    dx(1'b1, pcsb_pkg::PAGE_PORT, 7'h05, v0);
    dx(1'b1, pcsb_pkg::PAGE_PERIPH, 7'h05, v1);
    dx(1'b0, pcsb_pkg::PAGE_PORT, 7'h05, v0);
    dx(1'b0, pcsb_pkg::PAGE_PERIPH, 7'h05, v1);
    axi(1'b1, pcsb_pkg::REG_CTRL, 32'h1);
    `CHK("bresp", rs, pcsb_pkg::RESP_OKAY)
    op(pcsb_pkg::INS_LONG_JUMP, pcsb_pkg::PRESET_HI);
    `CHK("preset", fetch_preset_sel, 1'b0)
    axi(1'b0, pcsb_pkg::REG_PC_STAT, 32'h0);
    `CHK("pcreg", r[10:0], pcsb_pkg::PRESET_HI)
    axi(1'b0, 4'h2, 32'h0);
    `CHK("rresp", rs, pcsb_pkg::RESP_OKAY)
    `CHK("alias", r[0], 1'b1)
    repeat (4) @(posedge aclk);
    `CHK("left", expq.size(), 0)
    finish_test();
  end
endmodule
bind pcsb_core pcsb_core_sva u_sva (.*);
`default_nettype wire
